// ===== verilog/logic_io_defs.vh
// Offsets, reset values, field positions and timing counts of the virtual I/O bank
`ifndef LOGIC_IO_DEFS_VH
`define LOGIC_IO_DEFS_VH

`define ADDR_IN_STATE 8'h00
`define ADDR_IN_MODE 8'h04
`define ADDR_IN_SET 8'h08
`define ADDR_IN_CLEAR 8'h0C
`define ADDR_OUT_LOW 8'h10
`define ADDR_OUT_HIGH 8'h14
`define ADDR_ON_SEL_IN 8'h18
`define ADDR_OFF_SEL_IN 8'h1C
`define ADDR_ON_SEL_OUTL 8'h20
`define ADDR_OFF_SEL_OUTL 8'h24
`define ADDR_ON_SEL_OUTH 8'h28
`define ADDR_OFF_SEL_OUTH 8'h2C
`define ADDR_EVT_INFO 8'h30
`define ADDR_EVT_STAMP 8'h34
`define ADDR_EVT_POP 8'h38
`define ADDR_TIME 8'h3C
`define ADDR_IRQ_STATUS 8'h40
`define ADDR_IRQ_CLEAR 8'h44
`define ADDR_IRQ_ENABLE 8'h48

`define RST_IN_MODE 32'h00000000
`define RST_EVT_SEL 32'hFFFFFFFF
`define RST_IRQ_ENABLE 3'h0

`define EVT_VALID_BIT 31
`define EVT_GROUP_LSB 8
`define EVT_ON_BIT 7

`define GROUP_OUT_LOW 2'h0
`define GROUP_IN 2'h1
`define GROUP_OUT_HIGH 2'h2

`define IRQ_EVENT_BIT 0
`define IRQ_OVERRUN_BIT 1
`define IRQ_EXPIRED_BIT 2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define PULSE_TIME_US 5000
`define CLK_FREQ_MHZ 10
`define PULSE_CYCLES_CALC (`PULSE_TIME_US * `CLK_FREQ_MHZ)

`endif

// ===== verilog/pulse_input.v
// One command-driven input with latching and fixed-width pulse behaviour
`timescale 1ns/1ps
module pulse_input #(
   parameter [15:0] PULSE_CYCLES = 16'hC350
) (
   input wire clk,
   input wire rst,
   input wire set,
   input wire clr,
   input wire pulse_mode,
   output wire state,
   output wire expired
);
   reg state_q;
   reg expired_q;
   reg [15:0] cnt_q;

   assign state = state_q;
   assign expired = expired_q;

   always @(posedge clk) begin
      if (rst) begin
         state_q <= 1'b0;
         cnt_q <= 16'h0000;
         expired_q <= 1'b0;
      end else begin
         expired_q <= 1'b0;
         if (set) begin
            state_q <= 1'b1;
            cnt_q <= 16'h0000;
         end else if (clr) begin
            state_q <= 1'b0;
            cnt_q <= 16'h0000;
         end else if (state_q && pulse_mode) begin
            if (cnt_q == PULSE_CYCLES - 16'h0001) begin
               state_q <= 1'b0;
               cnt_q <= 16'h0000;
               expired_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end
      end
   end
endmodule // pulse_input

// ===== verilog/logic_io_bank.v
// Virtual I/O bank: 64 logic-driven outputs, 32 command-driven inputs, events, AXI4-Lite
// Operation
// - Sixty-four logic-driven output status bits
// - Outputs usable internally and readable remotely
// - Thirty-two inputs set only by commands
// - Reboot forces all inputs to zero
// - Per-input latching or pulse mode
// - Latching: set holds until clear
// - Pulse: bit returns to zero after 5 ms
// - Edges make ON/OFF events, selectable storage
// - Each event carries change time stamp
`timescale 1ns/1ps
`include "logic_io_defs.vh"
module logic_io_bank #(
   parameter [15:0] PULSE_CYCLES = `PULSE_CYCLES_CALC
) (
   input wire REF_CLK,
   input wire RST,
   input wire [63:0] LOGIC_RESULT,
   output wire [63:0] LOGIC_DRIVEN_OUTPUT,
   output wire [31:0] COMMAND_DRIVEN_INPUT,
   input wire MIMIC_STB,
   input wire MIMIC_VALUE,
   input wire [4:0] MIMIC_INDEX,
   output wire IRQ,
   input wire [7:0] AWADDR,
   input wire AWVALID,
   output wire AWREADY,
   input wire [31:0] WDATA,
   input wire [3:0] WSTRB,
   input wire WVALID,
   output wire WREADY,
   output wire [1:0] BRESP,
   output wire BVALID,
   input wire BREADY,
   input wire [7:0] ARADDR,
   input wire ARVALID,
   output wire ARREADY,
   output wire [31:0] RDATA,
   output wire [1:0] RRESP,
   output wire RVALID,
   input wire RREADY
);
   reg [63:0] logic_q;
   reg [31:0] mode_q;
   reg [31:0] on_sel_in_q;
   reg [31:0] off_sel_in_q;
   reg [31:0] on_sel_outl_q;
   reg [31:0] off_sel_outl_q;
   reg [31:0] on_sel_outh_q;
   reg [31:0] off_sel_outh_q;
   reg [31:0] time_q;
   reg [2:0] irq_st_q;
   reg [2:0] irq_en_q;
   reg head_valid_q;
   reg [1:0] head_group_q;
   reg [4:0] head_idx_q;
   reg head_on_q;
   reg [31:0] head_stamp_q;
   reg aw_hold_q;
   reg [7:0] awaddr_q;
   reg w_hold_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   reg [6:0] sel_idx;
   reg sel_any;
   reg [31:0] rd_d;
   reg rd_ok;
   reg wr_ok;
   integer k;

   wire [31:0] cmd_state;
   wire [31:0] expired;
   wire [95:0] all_sig;
   wire [95:0] on_sel;
   wire [95:0] off_sel;
   wire [95:0] pend;
   wire [95:0] edge_on;
   wire [95:0] overrun;
   wire [96*32-1:0] stamp_flat;
   wire [95:0] take;
   wire wr_fire;
   wire [31:0] wmask;
   wire [31:0] wbits;
   wire [31:0] axi_set;
   wire [31:0] axi_clr;
   wire [31:0] mimic_sel;
   wire [31:0] set_vec;
   wire [31:0] clr_vec;
   wire load;
   wire [2:0] irq_set;
   wire [2:0] irq_clr;

   assign LOGIC_DRIVEN_OUTPUT = logic_q;
   assign COMMAND_DRIVEN_INPUT = cmd_state;

   // Write and read handshakes of the AXI4-Lite slave
   assign AWREADY = !aw_hold_q && !bvalid_q;
   assign WREADY = !w_hold_q && !bvalid_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   assign ARREADY = !rvalid_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;

   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wbits = wdata_q & wmask;

   // Inputs driven only by commands
   // Bus and mimic command paths
   assign axi_set = (wr_fire && awaddr_q == `ADDR_IN_SET) ? wbits : 32'h00000000;
   assign axi_clr = (wr_fire && awaddr_q == `ADDR_IN_CLEAR) ? wbits : 32'h00000000;
   assign mimic_sel = MIMIC_STB ? (32'h00000001 << MIMIC_INDEX) : 32'h00000000;
   assign set_vec = axi_set | (MIMIC_VALUE ? mimic_sel : 32'h00000000);
   assign clr_vec = axi_clr | (MIMIC_VALUE ? 32'h00000000 : mimic_sel);

   genvar i;
   generate
      for (i = 0; i < 32; i = i + 1) begin : g_in
         pulse_input #(
            .PULSE_CYCLES(PULSE_CYCLES)
         ) u_in (
            .clk(REF_CLK),
            .rst(RST),
            .set(set_vec[i]),
            .clr(clr_vec[i]),
            .pulse_mode(mode_q[i]),
            .state(cmd_state[i]),
            .expired(expired[i])
         );
      end
   endgenerate

   assign all_sig = {logic_q[63:32], cmd_state, logic_q[31:0]};
   assign on_sel = {on_sel_outh_q, on_sel_in_q, on_sel_outl_q};
   assign off_sel = {off_sel_outh_q, off_sel_in_q, off_sel_outl_q};
   assign load = sel_any && !head_valid_q;
   assign take = load ? (96'h1 << sel_idx) : 96'h0;

   generate
      for (i = 0; i < 96; i = i + 1) begin : g_ev
         reg prev_q;
         reg pend_q;
         reg on_q;
         reg [31:0] stamp_q;
         wire rise;
         wire fall;
         wire keep;
         assign rise = all_sig[i] && !prev_q;
         assign fall = !all_sig[i] && prev_q;
         assign keep = (rise && on_sel[i]) || (fall && off_sel[i]);
         assign pend[i] = pend_q;
         assign edge_on[i] = on_q;
         assign stamp_flat[i*32 +: 32] = stamp_q;
         assign overrun[i] = keep && pend_q && !take[i];
         always @(posedge REF_CLK) begin
            if (RST) begin
               prev_q <= 1'b0;
               pend_q <= 1'b0;
               on_q <= 1'b0;
               stamp_q <= 32'h00000000;
            end else begin
               prev_q <= all_sig[i];
               if (keep) begin
                  pend_q <= 1'b1;
                  on_q <= rise;
                  stamp_q <= time_q;
               end else if (take[i]) begin
                  pend_q <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Lowest pending index is handed to the head first
   always @* begin
      sel_idx = 7'h00;
      sel_any = 1'b0;
      for (k = 95; k >= 0; k = k - 1) begin
         if (pend[k]) begin
            sel_idx = k[6:0];
            sel_any = 1'b1;
         end
      end
   end

   assign irq_set = {|expired, |overrun, load};
   assign irq_clr = (wr_fire && awaddr_q == `ADDR_IRQ_CLEAR) ? wbits[2:0] : 3'h0;
   assign IRQ = |(irq_st_q & irq_en_q);

   always @(posedge REF_CLK) begin
      if (RST) begin
         logic_q <= 64'h0;
         time_q <= 32'h00000000;
         irq_st_q <= 3'h0;
         head_valid_q <= 1'b0;
         head_group_q <= 2'h0;
         head_idx_q <= 5'h00;
         head_on_q <= 1'b0;
         head_stamp_q <= 32'h00000000;
      end else begin
         logic_q <= LOGIC_RESULT;
         time_q <= time_q + 32'h00000001;
         // Set wins over a clear in the same cycle
         irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
         if (load) begin
            head_valid_q <= 1'b1;
            head_group_q <= sel_idx[6:5];
            head_idx_q <= sel_idx[4:0];
            head_on_q <= edge_on[sel_idx];
            head_stamp_q <= stamp_flat[sel_idx*32 +: 32];
         end else if (wr_fire && awaddr_q == `ADDR_EVT_POP) begin
            head_valid_q <= 1'b0;
         end
      end
   end

   // Register writes and address phase handling
   always @* begin
      case (awaddr_q)
         `ADDR_IN_MODE, `ADDR_IN_SET, `ADDR_IN_CLEAR, `ADDR_ON_SEL_IN, `ADDR_OFF_SEL_IN,
         `ADDR_ON_SEL_OUTL, `ADDR_OFF_SEL_OUTL, `ADDR_ON_SEL_OUTH, `ADDR_OFF_SEL_OUTH,
         `ADDR_EVT_POP, `ADDR_IRQ_CLEAR, `ADDR_IRQ_ENABLE: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always @(posedge REF_CLK) begin
      if (RST) begin
         aw_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         w_hold_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         mode_q <= `RST_IN_MODE;
         on_sel_in_q <= `RST_EVT_SEL;
         off_sel_in_q <= `RST_EVT_SEL;
         on_sel_outl_q <= `RST_EVT_SEL;
         off_sel_outl_q <= `RST_EVT_SEL;
         on_sel_outh_q <= `RST_EVT_SEL;
         off_sel_outh_q <= `RST_EVT_SEL;
         irq_en_q <= `RST_IRQ_ENABLE;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_hold_q <= 1'b1;
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
         end
         if (bvalid_q && BREADY) begin
            bvalid_q <= 1'b0;
         end
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            case (awaddr_q)
               `ADDR_IN_MODE: mode_q <= (mode_q & ~wmask) | wbits;
               `ADDR_ON_SEL_IN: on_sel_in_q <= (on_sel_in_q & ~wmask) | wbits;
               `ADDR_OFF_SEL_IN: off_sel_in_q <= (off_sel_in_q & ~wmask) | wbits;
               `ADDR_ON_SEL_OUTL: on_sel_outl_q <= (on_sel_outl_q & ~wmask) | wbits;
               `ADDR_OFF_SEL_OUTL: off_sel_outl_q <= (off_sel_outl_q & ~wmask) | wbits;
               `ADDR_ON_SEL_OUTH: on_sel_outh_q <= (on_sel_outh_q & ~wmask) | wbits;
               `ADDR_OFF_SEL_OUTH: off_sel_outh_q <= (off_sel_outh_q & ~wmask) | wbits;
               `ADDR_IRQ_ENABLE: irq_en_q <= (irq_en_q & ~wmask[2:0]) | wbits[2:0];
               default: irq_en_q <= irq_en_q;
            endcase
         end
      end
   end

   // Read side
   always @* begin
      rd_d = 32'h00000000;
      rd_ok = 1'b1;
      case (ARADDR)
         `ADDR_IN_STATE: rd_d = cmd_state;
         `ADDR_IN_MODE: rd_d = mode_q;
         `ADDR_IN_SET: rd_d = 32'h00000000;
         `ADDR_IN_CLEAR: rd_d = 32'h00000000;
         `ADDR_OUT_LOW: rd_d = logic_q[31:0];
         `ADDR_OUT_HIGH: rd_d = logic_q[63:32];
         `ADDR_ON_SEL_IN: rd_d = on_sel_in_q;
         `ADDR_OFF_SEL_IN: rd_d = off_sel_in_q;
         `ADDR_ON_SEL_OUTL: rd_d = on_sel_outl_q;
         `ADDR_OFF_SEL_OUTL: rd_d = off_sel_outl_q;
         `ADDR_ON_SEL_OUTH: rd_d = on_sel_outh_q;
         `ADDR_OFF_SEL_OUTH: rd_d = off_sel_outh_q;
         `ADDR_EVT_INFO: begin
            rd_d[`EVT_VALID_BIT] = head_valid_q;
            rd_d[`EVT_GROUP_LSB +: 2] = head_group_q;
            rd_d[`EVT_ON_BIT] = head_on_q;
            rd_d[4:0] = head_idx_q;
         end
         `ADDR_EVT_STAMP: rd_d = head_stamp_q;
         `ADDR_EVT_POP: rd_d = 32'h00000000;
         `ADDR_TIME: rd_d = time_q;
         `ADDR_IRQ_STATUS: rd_d[2:0] = irq_st_q;
         `ADDR_IRQ_CLEAR: rd_d = 32'h00000000;
         `ADDR_IRQ_ENABLE: rd_d[2:0] = irq_en_q;
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge REF_CLK) begin
      if (RST) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
      end else begin
         if (ARVALID && ARREADY) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_d;
            rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_q && RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end
endmodule // logic_io_bank

// ===== tb/logic_io_bank_properties.sv
// Port assertions for the virtual I/O bank
`timescale 1ns/1ps
module logic_io_bank_checker #(
   parameter [15:0] PULSE_CYCLES = 16'h0014
) (
   input wire REF_CLK,
   input wire RST,
   input wire [63:0] LOGIC_RESULT,
   input wire [63:0] LOGIC_DRIVEN_OUTPUT,
   input wire [31:0] COMMAND_DRIVEN_INPUT,
   input wire MIMIC_STB,
   input wire MIMIC_VALUE,
   input wire [4:0] MIMIC_INDEX,
   input wire AWVALID,
   input wire AWREADY,
   input wire WVALID,
   input wire WREADY,
   input wire BVALID,
   input wire ARVALID,
   input wire ARREADY,
   input wire RVALID
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   // High time of input 0 since its latest mimic set command
   reg [15:0] cnt_q;
   wire restart = MIMIC_STB && MIMIC_VALUE && MIMIC_INDEX == 5'h00;
   wire [15:0] cnt_d = (RST || !COMMAND_DRIVEN_INPUT[0] || restart) ? 16'h0000 : cnt_q + 16'h0001;
   always @(posedge REF_CLK) begin
      cnt_q <= cnt_d;
   end
   property p_out_follow;
      !$past(RST) |-> LOGIC_DRIVEN_OUTPUT == $past(LOGIC_RESULT);
   endproperty
   a_out_follow: assert property (p_out_follow)
      else $error("output not following logic result");
   property p_boot_zero;
      $fell(RST) |-> COMMAND_DRIVEN_INPUT == 32'h00000000;
   endproperty
   a_boot_zero: assert property (p_boot_zero)
      else $error("inputs not zero after reboot");
   property p_set_one;
      MIMIC_STB && MIMIC_VALUE |=> COMMAND_DRIVEN_INPUT[$past(MIMIC_INDEX)];
   endproperty
   a_set_one: assert property (p_set_one)
      else $error("set command did not raise input");
   property p_clr_zero;
      MIMIC_STB && !MIMIC_VALUE |=> !COMMAND_DRIVEN_INPUT[$past(MIMIC_INDEX)] || $rose(BVALID);
   endproperty
   a_clr_zero: assert property (p_clr_zero)
      else $error("clear command did not drop input");
   property p_pulse_len;
      $fell(COMMAND_DRIVEN_INPUT[0]) && !$rose(BVALID) && !$past(MIMIC_STB)
         |-> cnt_q == PULSE_CYCLES;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("pulse length wrong");
   property p_wr_resp;
      AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID;
   endproperty
   a_wr_resp: assert property (p_wr_resp)
      else $error("write response late");
   property p_wr_busy;
      BVALID |-> !AWREADY && !WREADY;
   endproperty
   a_wr_busy: assert property (p_wr_busy)
      else $error("write accepted during response");
   property p_rd_resp;
      ARVALID && ARREADY |=> RVALID && !ARREADY;
   endproperty
   a_rd_resp: assert property (p_rd_resp)
      else $error("read response late");
endmodule // logic_io_bank_checker

bind logic_io_bank logic_io_bank_checker #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (
   .REF_CLK(REF_CLK), .RST(RST), .LOGIC_RESULT(LOGIC_RESULT),
   .LOGIC_DRIVEN_OUTPUT(LOGIC_DRIVEN_OUTPUT), .COMMAND_DRIVEN_INPUT(COMMAND_DRIVEN_INPUT),
   .MIMIC_STB(MIMIC_STB), .MIMIC_VALUE(MIMIC_VALUE), .MIMIC_INDEX(MIMIC_INDEX),
   .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
   .BVALID(BVALID), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID)
);

// ===== tb/mimic_switch.sv
// Model of the local mimic switch issuing input commands
`timescale 1ns/1ps
module mimic_switch (
   input wire clk,
   output reg stb,
   output reg value,
   output reg [4:0] index
);
   initial begin
      stb = 1'b0;
      value = 1'b0;
      index = 5'h00;
   end
   task cmd(input [4:0] idx, input val);
      begin
         stb <= 1'b1;
         value <= val;
         index <= idx;
         @(posedge clk);
         stb <= 1'b0;
         value <= ~val;
         index <= ~idx;
      end
   endtask
endmodule // mimic_switch

// ===== tb/test_logic_io_bank.sv
// Self-checking bench for the virtual I/O bank
`timescale 1ns/1ps
`include "logic_io_defs.vh"
module test_logic_io_bank;
   localparam [15:0] P = 16'h0014;
   reg REF_CLK = 1'b0;
   reg RST = 1'b1;
   reg [63:0] LOGIC_RESULT = 64'h0;
   reg [7:0] AWADDR = 8'h00;
   reg [7:0] ARADDR = 8'h00;
   reg [31:0] WDATA = 32'h0;
   reg AWVALID = 1'b0;
   reg WVALID = 1'b0;
   reg BREADY = 1'b0;
   reg ARVALID = 1'b0;
   reg RREADY = 1'b0;
   wire [63:0] LOGIC_DRIVEN_OUTPUT;
   wire [31:0] COMMAND_DRIVEN_INPUT, RDATA;
   wire [4:0] MIMIC_INDEX;
   wire [1:0] BRESP, RRESP;
   wire MIMIC_STB, MIMIC_VALUE, IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID;
   integer seed = 95470;
   integer n_mismatch = 0;
   integer cmp_count = 0;
   integer i, n;
   reg [31:0] d, st, ex;
   reg [1:0] r;
   reg [63:0] lr;
   reg aw, w;

   always #50 REF_CLK = ~REF_CLK;

   logic_io_bank #(.PULSE_CYCLES(P)) i_dut (
      .REF_CLK(REF_CLK), .RST(RST), .LOGIC_RESULT(LOGIC_RESULT),
      .LOGIC_DRIVEN_OUTPUT(LOGIC_DRIVEN_OUTPUT), .COMMAND_DRIVEN_INPUT(COMMAND_DRIVEN_INPUT),
      .MIMIC_STB(MIMIC_STB), .MIMIC_VALUE(MIMIC_VALUE), .MIMIC_INDEX(MIMIC_INDEX), .IRQ(IRQ),
      .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
      .RVALID(RVALID), .RREADY(RREADY)
   );

   mimic_switch i_sw (.clk(REF_CLK), .stb(MIMIC_STB), .value(MIMIC_VALUE), .index(MIMIC_INDEX));

   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
         end
      end
   endtask

   task axw(input [7:0] a, input [31:0] v);
      begin
         AWADDR <= a;
         WDATA <= v;
         AWVALID <= 1'b1;
         WVALID <= 1'b1;
         BREADY <= 1'b1;
         aw = 1'b0;
         w = 1'b0;
         while (!(aw && w)) begin
            @(posedge REF_CLK);
            if (!aw && AWREADY) begin
               aw = 1'b1;
               AWVALID <= 1'b0;
            end
            if (!w && WREADY) begin
               w = 1'b1;
               WVALID <= 1'b0;
            end
         end
         @(posedge REF_CLK);
         while (!BVALID) @(posedge REF_CLK);
         r = BRESP;
         BREADY <= 1'b0;
         @(posedge REF_CLK);
      end
   endtask

   task axr(input [7:0] a);
      begin
         ARADDR <= a;
         ARVALID <= 1'b1;
         RREADY <= 1'b1;
         @(posedge REF_CLK);
         while (!ARREADY) @(posedge REF_CLK);
         ARVALID <= 1'b0;
         @(posedge REF_CLK);
         while (!RVALID) @(posedge REF_CLK);
         d = RDATA;
         r = RRESP;
         RREADY <= 1'b0;
         @(posedge REF_CLK);
      end
   endtask

   function [31:0] evt(input on, input [4:0] idx);
      evt = {1'b1, 21'h0, `GROUP_IN, on, 2'h0, idx};
   endfunction

   function [31:0] latch(input [31:0] cur, input [31:0] s, input [31:0] c);
      latch = (cur | s) & ~c;
   endfunction

   task print_verdict;
      begin
         $display("checks %0d, mismatches %0d", cmp_count, n_mismatch);
         if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   initial begin
      repeat (50000) @(posedge REF_CLK);
      n_mismatch = n_mismatch + 1;
      print_verdict;
   end

   initial begin
      repeat (8) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      chk(COMMAND_DRIVEN_INPUT, 32'h0);
      chk(IRQ, 32'h0);
      axr(`ADDR_IN_MODE);
      chk(d, `RST_IN_MODE);
      axr(`ADDR_ON_SEL_OUTH);
      chk(d, `RST_EVT_SEL);
      for (i = 0; i < 4; i = i + 1) begin
         lr = {$random(seed), $random(seed)};
         LOGIC_RESULT <= lr;
         repeat (2) @(posedge REF_CLK);
         chk(LOGIC_DRIVEN_OUTPUT[31:0], lr[31:0]);
         axr(`ADDR_OUT_HIGH);
         chk(d, lr[63:32]);
      end
      ex = 32'h0;
      for (i = 0; i < 6; i = i + 1) begin
         st = $random(seed) & 32'hFFFFFFFE;
         axw(i[0] ? `ADDR_IN_CLEAR : `ADDR_IN_SET, st);
         ex = latch(ex, i[0] ? 32'h0 : st, i[0] ? st : 32'h0);
         chk(COMMAND_DRIVEN_INPUT, ex);
         axr(`ADDR_IN_STATE);
         chk(d, ex);
      end
      // Refused accesses leave the inputs alone
      axw(`ADDR_IN_STATE, 32'hFFFFFFFF);
      chk(r, `RESP_SLVERR);
      axw(8'h80, 32'h0000FFFF);
      chk(r, `RESP_SLVERR);
      axr(8'h80);
      chk({r, d[29:0]}, {`RESP_SLVERR, 30'h0});
      chk(COMMAND_DRIVEN_INPUT, ex);
      axw(`ADDR_IN_CLEAR, 32'hFFFFFFFF);
      i_sw.cmd(5'h05, 1'b1);
      repeat (3 * P) @(posedge REF_CLK);
      chk(COMMAND_DRIVEN_INPUT, 32'h20);
      n = 0;
      axr(`ADDR_EVT_INFO);
      while (d[31] && n < 200) begin
         axw(`ADDR_EVT_POP, 32'h0);
         axr(`ADDR_EVT_INFO);
         n = n + 1;
      end
      axw(`ADDR_IRQ_CLEAR, 32'h7);
      axw(`ADDR_IRQ_ENABLE, 32'h1);
      chk(IRQ, 32'h0);
      i_sw.cmd(5'h07, 1'b1);
      n = 0;
      while (IRQ !== 1'b1 && n < 20) begin
         @(posedge REF_CLK);
         n = n + 1;
      end
      chk(IRQ, 32'h1);
      axr(`ADDR_EVT_INFO);
      chk(d, evt(1'b1, 5'h07));
      axr(`ADDR_EVT_STAMP);
      st = d;
      axr(`ADDR_TIME);
      chk(st != 32'h0 && st < d, 32'h1);
      axw(`ADDR_EVT_POP, 32'h0);
      axw(`ADDR_ON_SEL_IN, 32'h0);
      axw(`ADDR_IRQ_ENABLE, 32'h0);
      axw(`ADDR_IRQ_CLEAR, 32'h7);
      i_sw.cmd(5'h07, 1'b0);
      repeat (4) @(posedge REF_CLK);
      chk(IRQ, 32'h0);
      axr(`ADDR_EVT_INFO);
      chk(d, evt(1'b0, 5'h07));
      axw(`ADDR_EVT_POP, 32'h0);
      i_sw.cmd(5'h07, 1'b1);
      repeat (4) @(posedge REF_CLK);
      axr(`ADDR_EVT_INFO);
      chk(d[31], 32'h0);
      axw(`ADDR_IN_MODE, 32'h1);
      i_sw.cmd(5'h00, 1'b1);
      repeat (P / 2) @(posedge REF_CLK);
      i_sw.cmd(5'h00, 1'b1);
      repeat (P - 2) @(posedge REF_CLK);
      chk(COMMAND_DRIVEN_INPUT[0], 32'h1);
      repeat (4) @(posedge REF_CLK);
      chk(COMMAND_DRIVEN_INPUT[0], 32'h0);
      axr(`ADDR_IRQ_STATUS);
      chk(d[2], 32'h1);
      i_sw.cmd(5'h00, 1'b1);
      n = 0;
      for (i = 0; i < 2 * P; i = i + 1) begin
         n = COMMAND_DRIVEN_INPUT[0] ? 3 * P : (n > 0 ? n - 1 : 0);
         LOGIC_RESULT <= {lr[63:1], n > 0};
         @(posedge REF_CLK);
      end
      chk({COMMAND_DRIVEN_INPUT[0], LOGIC_DRIVEN_OUTPUT[0]}, 32'h1);
      // Mid-run reboot with inputs high and pulse mode on
      st = ($random(seed) & 32'hFFFFFFFE) | 32'h00000002;
      axw(`ADDR_IN_SET, st);
      chk(COMMAND_DRIVEN_INPUT, latch(32'h000000A0, st, 32'h0));
      RST <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      chk(COMMAND_DRIVEN_INPUT, 32'h0);
      axr(`ADDR_IN_MODE);
      chk(d, `RST_IN_MODE);
      print_verdict;
   end
endmodule // test_logic_io_bank
